// [rtl/bpv_pkg.sv]
// Operation
// - Termination mode enable switches buck six reference to buck five feedback halved.
// - Termination mode disables buck six voltage scaling; target is half of buck five.
// - Buck six starts with or after buck five; same slot means tracking throughout.
// - Later start ramps to tracking-start level first, then follows half of buck five; code ramps to run or standby setpoint instead if that level is zero.
// - Buck five disabled: buck six keeps tracking, both discharge with pull-downs.
// - Buck five re-enabled: it ramps to setpoint, buck six stays at half.
// - Buck six alone disabled: select bit 0 high impedance, 1 pull-down.
// - Buck six alone re-enabled ramps to run or standby setpoint, then tracks; code tracks at once instead with same slot and buck five enabled.
// - Quad phase: bucks one to four form one rail under buck one registers.
// - Triple phase: bucks one to three under buck one; buck four stays single.
// - First pair dual phase: bucks one and two under buck one registers.
// - Every member phase keeps its own phase-shift selection field.
// - First group field: 00 single, 01 dual, 10 quad, 11 triple.
// - Second pair field: 00 single, 01 dual under buck four; others reserved.
// - Quad or triple first group ignores the second pair field.
// - Third pair field: 00 single, 01 dual under buck five; others reserved.
// - Phase-shift fields reset to 111, zero degrees; 000 to 110 are 45-degree steps.
package bpv_pkg;

  localparam int NUM_BUCK = 6;
  localparam int BUCK_ONE = 0;
  localparam int BUCK_TWO = 1;
  localparam int BUCK_THREE = 2;
  localparam int BUCK_FOUR = 3;
  localparam int BUCK_FIVE = 4;
  localparam int BUCK_SIX = 5;
  localparam logic [1:0] GRP_SINGLE = 2'h0;
  localparam logic [1:0] GRP_DUAL = 2'h1;
  localparam logic [1:0] GRP_QUAD = 2'h2;
  localparam logic [1:0] GRP_TRIPLE = 2'h3;
  localparam logic [2:0] PHASE_RESET = 3'h7;
  localparam logic [7:0] SETPOINT_ZERO = 8'h00;
  localparam logic [7:0] RAMP_STEP = 8'h01;
  localparam logic [8:0] RAMP_LIMIT = 9'h101;

  typedef enum {
    BPV_OFF,
    BPV_RAMP_START,
    BPV_RAMP_SETPOINT,
    BPV_TRACK,
    BPV_DISCHARGE
  } bpv_state_t;

  typedef struct packed {
    logic [1:0] first_group_phase_config;
    logic [1:0] second_pair_phase_config;
    logic [1:0] third_pair_phase_config;
    logic termination_disable_pulldown_select;
    logic [7:0] termination_track_start_level;
  } bpv_otp_t;

  // Index of the buck whose registers steer each buck's loop.
  typedef struct packed {
    logic [5:0][2:0] ctrl_src;
  } bpv_group_t;

endpackage

// [rtl/bpv_ctrl.sv]
`timescale 1ns/10ps
module bpv_ctrl (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic otp_load,
  input wire bpv_pkg::bpv_otp_t otp_cfg,
  input wire logic termination_mode_enable,
  input wire logic standby_mode,
  input wire logic buck_five_enable,
  input wire logic buck_six_enable,
  input wire logic buck_six_same_slot,
  input wire logic [7:0] buck_five_feedback_code,
  input wire logic [7:0] buck_six_run_setpoint,
  input wire logic [7:0] buck_six_standby_setpoint,
  input wire logic [5:0] phase_wr,
  input wire logic [2:0] phase_wdata,
  output bpv_pkg::bpv_group_t group_ff,
  output logic buck_four_single_ff,
  output logic [5:0][2:0] phase_shift_select_ff,
  output logic track_reference_ff,
  output logic buck_six_dvs_enable_ff,
  output logic [7:0] buck_six_target_ff,
  output logic buck_six_on_ff,
  output logic buck_five_pulldown_ff,
  output logic buck_six_pulldown_ff
);

  // --------------------------------------------------------------
  // Phase grouping
  // --------------------------------------------------------------
  logic otp_done_ff;
  bpv_pkg::bpv_group_t nxt_group;
  logic nxt_four_single;

  always_comb begin
    nxt_group.ctrl_src = '0;
    for (int i = 0; i < bpv_pkg::NUM_BUCK; i++) begin
      nxt_group.ctrl_src[i] = 3'(i);
    end
    nxt_four_single = 1'b1;
    unique case (otp_cfg.first_group_phase_config)
      bpv_pkg::GRP_DUAL: begin
        nxt_group.ctrl_src[bpv_pkg::BUCK_TWO] = 3'(bpv_pkg::BUCK_ONE);
      end
      bpv_pkg::GRP_QUAD: begin
        for (int i = bpv_pkg::BUCK_TWO; i <= bpv_pkg::BUCK_FOUR; i++) begin
          nxt_group.ctrl_src[i] = 3'(bpv_pkg::BUCK_ONE);
        end
        nxt_four_single = 1'b0;
      end
      bpv_pkg::GRP_TRIPLE: begin
        for (int i = bpv_pkg::BUCK_TWO; i <= bpv_pkg::BUCK_THREE; i++) begin
          nxt_group.ctrl_src[i] = 3'(bpv_pkg::BUCK_ONE);
        end
      end
      bpv_pkg::GRP_SINGLE: begin
      end
    endcase
    // Quad and triple override the second pair field entirely.
    if (otp_cfg.first_group_phase_config != bpv_pkg::GRP_QUAD &&
        otp_cfg.first_group_phase_config != bpv_pkg::GRP_TRIPLE &&
        otp_cfg.second_pair_phase_config == bpv_pkg::GRP_DUAL) begin
      nxt_group.ctrl_src[bpv_pkg::BUCK_THREE] = 3'(bpv_pkg::BUCK_FOUR);
      nxt_four_single = 1'b0;
    end
    if (otp_cfg.third_pair_phase_config == bpv_pkg::GRP_DUAL) begin
      nxt_group.ctrl_src[bpv_pkg::BUCK_SIX] = 3'(bpv_pkg::BUCK_FIVE);
    end
  end

  // Fields are captured once after reset; later OTP strobes are ignored.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      otp_done_ff <= 1'b0;
      group_ff.ctrl_src <= '0;
      buck_four_single_ff <= 1'b1;
    end else if (otp_load && !otp_done_ff) begin
      otp_done_ff <= 1'b1;
      group_ff <= nxt_group;
      buck_four_single_ff <= nxt_four_single;
    end
  end

  logic pdown_sel_ff;
  logic [7:0] track_start_ff;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pdown_sel_ff <= 1'b0;
      track_start_ff <= bpv_pkg::SETPOINT_ZERO;
    end else if (otp_load && !otp_done_ff) begin
      pdown_sel_ff <= otp_cfg.termination_disable_pulldown_select;
      track_start_ff <= otp_cfg.termination_track_start_level;
    end
  end

  // --------------------------------------------------------------
  // Phase shift fields
  // --------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < bpv_pkg::NUM_BUCK; g++) begin : g_phase
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          phase_shift_select_ff[g] <= bpv_pkg::PHASE_RESET;
        end else if (phase_wr[g]) begin
          phase_shift_select_ff[g] <= phase_wdata;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------
  // Termination mode sequencing for buck six
  // --------------------------------------------------------------
  bpv_pkg::bpv_state_t state_ff;
  bpv_pkg::bpv_state_t nxt_state;
  logic [7:0] half_five;
  logic [7:0] six_setpoint;
  logic [7:0] nxt_target;

  assign half_five = {1'b0, buck_five_feedback_code[7:1]};
  assign six_setpoint = standby_mode ? buck_six_standby_setpoint : buck_six_run_setpoint;

  function automatic logic [7:0] step_to(input logic [7:0] cur, input logic [7:0] goal);
    if (cur < goal) begin
      step_to = 8'(cur + bpv_pkg::RAMP_STEP);
    end else if (cur > goal) begin
      step_to = 8'(cur - bpv_pkg::RAMP_STEP);
    end else begin
      step_to = cur;
    end
  endfunction

  always_comb begin
    nxt_state = state_ff;
    nxt_target = buck_six_target_ff;
    unique case (state_ff)
      bpv_pkg::BPV_OFF: begin
        nxt_target = bpv_pkg::SETPOINT_ZERO;
        if (buck_six_enable && termination_mode_enable) begin
          if (buck_six_same_slot && buck_five_enable) begin
            nxt_state = bpv_pkg::BPV_TRACK;
          end else if (otp_done_ff && track_start_ff != bpv_pkg::SETPOINT_ZERO && !buck_six_on_ff) begin
            nxt_state = bpv_pkg::BPV_RAMP_START;
          end else begin
            nxt_state = bpv_pkg::BPV_RAMP_SETPOINT;
          end
        end
      end
      bpv_pkg::BPV_RAMP_START: begin
        nxt_target = step_to(buck_six_target_ff, track_start_ff);
        if (buck_six_target_ff == track_start_ff) begin
          nxt_state = bpv_pkg::BPV_TRACK;
        end
      end
      bpv_pkg::BPV_RAMP_SETPOINT: begin
        nxt_target = step_to(buck_six_target_ff, six_setpoint);
        if (buck_six_target_ff == six_setpoint) begin
          nxt_state = bpv_pkg::BPV_TRACK;
        end
      end
      bpv_pkg::BPV_TRACK: begin
        // Tracking continues through buck five off and back on.
        nxt_target = half_five;
      end
      bpv_pkg::BPV_DISCHARGE: begin
        nxt_target = bpv_pkg::SETPOINT_ZERO;
        nxt_state = bpv_pkg::BPV_OFF;
      end
    endcase
    if (state_ff != bpv_pkg::BPV_OFF && state_ff != bpv_pkg::BPV_DISCHARGE &&
        (!buck_six_enable || !termination_mode_enable)) begin
      nxt_state = bpv_pkg::BPV_DISCHARGE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff <= bpv_pkg::BPV_OFF;
      buck_six_target_ff <= bpv_pkg::SETPOINT_ZERO;
    end else begin
      state_ff <= nxt_state;
      buck_six_target_ff <= nxt_target;
    end
  end

  // Remembers that buck six has run, so a later enable is a re-enable.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      buck_six_on_ff <= 1'b0;
    end else if (nxt_state == bpv_pkg::BPV_TRACK) begin
      buck_six_on_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      track_reference_ff <= 1'b0;
      buck_six_dvs_enable_ff <= 1'b1;
    end else begin
      track_reference_ff <= (nxt_state == bpv_pkg::BPV_TRACK);
      buck_six_dvs_enable_ff <= !termination_mode_enable;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      buck_five_pulldown_ff <= 1'b0;
      buck_six_pulldown_ff <= 1'b0;
    end else begin
      buck_five_pulldown_ff <= termination_mode_enable && !buck_five_enable;
      if (termination_mode_enable && !buck_five_enable) begin
        buck_six_pulldown_ff <= 1'b1;
      end else begin
        buck_six_pulldown_ff <= !buck_six_enable && pdown_sel_ff;
      end
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_track_half: assert property (@(posedge sys_clk) disable iff (srst)
    state_ff == bpv_pkg::BPV_TRACK && $stable(half_five) |=> buck_six_target_ff == $past(half_five))
    else $error("Buck six target not half of buck five.");
  a_track_ref: assert property (@(posedge sys_clk) disable iff (srst)
    track_reference_ff |-> state_ff == bpv_pkg::BPV_TRACK)
    else $error("Tracking reference outside tracking state.");
  a_dvs_off: assert property (@(posedge sys_clk) disable iff (srst)
    termination_mode_enable |=> !buck_six_dvs_enable_ff)
    else $error("Voltage scaling left on in termination mode.");
  a_same_slot: assert property (@(posedge sys_clk) disable iff (srst)
    state_ff == bpv_pkg::BPV_OFF && buck_six_enable && termination_mode_enable && buck_six_same_slot
    && buck_five_enable |=> state_ff == bpv_pkg::BPV_TRACK)
    else $error("Same slot start did not track at once.");
  a_ramp_start: assert property (@(posedge sys_clk) disable iff (srst)
    state_ff == bpv_pkg::BPV_RAMP_START && buck_six_target_ff != track_start_ff
    && buck_six_enable && termination_mode_enable |=> state_ff == bpv_pkg::BPV_RAMP_START)
    else $error("Tracking began before start level.");
  a_five_off_pd: assert property (@(posedge sys_clk) disable iff (srst)
    termination_mode_enable && !buck_five_enable |=> buck_five_pulldown_ff && buck_six_pulldown_ff)
    else $error("Pull-downs not engaged with buck five off.");
  a_six_off_pd: assert property (@(posedge sys_clk) disable iff (srst)
    !buck_six_enable && buck_five_enable |=> buck_six_pulldown_ff == pdown_sel_ff)
    else $error("Buck six disable pull-down mismatch.");
  a_reset_phase: assert property (@(posedge sys_clk)
    srst |=> phase_shift_select_ff[0] == bpv_pkg::PHASE_RESET)
    else $error("Phase field reset value wrong.");
  a_group_static: assert property (@(posedge sys_clk) disable iff (srst)
    otp_done_ff |=> $stable(group_ff))
    else $error("Group configuration changed after load.");

  // --------------------------------------------------------------
  // Grouping and phase write checks
  // --------------------------------------------------------------
  // The grouping ones look only at the capture cycle, since the fields are static afterwards.
  a_quad_group: assert property (@(posedge sys_clk) disable iff (srst)
    otp_load && !otp_done_ff && otp_cfg.first_group_phase_config == bpv_pkg::GRP_QUAD
    |=> group_ff.ctrl_src[bpv_pkg::BUCK_FOUR] == 3'(bpv_pkg::BUCK_ONE) && !buck_four_single_ff)
    else $error("Quad grouping not under buck one.");
  a_triple_group: assert property (@(posedge sys_clk) disable iff (srst)
    otp_load && !otp_done_ff && otp_cfg.first_group_phase_config == bpv_pkg::GRP_TRIPLE
    |=> group_ff.ctrl_src[bpv_pkg::BUCK_THREE] == 3'(bpv_pkg::BUCK_ONE) && buck_four_single_ff)
    else $error("Triple grouping wrong or buck four not single.");
  a_dual_group: assert property (@(posedge sys_clk) disable iff (srst)
    otp_load && !otp_done_ff && otp_cfg.first_group_phase_config == bpv_pkg::GRP_DUAL
    |=> group_ff.ctrl_src[bpv_pkg::BUCK_TWO] == 3'(bpv_pkg::BUCK_ONE))
    else $error("First pair dual grouping not under buck one.");
  a_second_pair: assert property (@(posedge sys_clk) disable iff (srst)
    otp_load && !otp_done_ff && otp_cfg.first_group_phase_config == bpv_pkg::GRP_SINGLE
    && otp_cfg.second_pair_phase_config == bpv_pkg::GRP_DUAL
    |=> group_ff.ctrl_src[bpv_pkg::BUCK_THREE] == 3'(bpv_pkg::BUCK_FOUR))
    else $error("Second pair dual grouping not under buck four.");
  a_second_ignored: assert property (@(posedge sys_clk) disable iff (srst)
    otp_load && !otp_done_ff && otp_cfg.first_group_phase_config == bpv_pkg::GRP_QUAD
    |=> group_ff.ctrl_src[bpv_pkg::BUCK_THREE] == 3'(bpv_pkg::BUCK_ONE))
    else $error("Second pair field not overridden.");
  a_third_pair: assert property (@(posedge sys_clk) disable iff (srst)
    otp_load && !otp_done_ff && otp_cfg.third_pair_phase_config == bpv_pkg::GRP_DUAL
    |=> group_ff.ctrl_src[bpv_pkg::BUCK_SIX] == 3'(bpv_pkg::BUCK_FIVE))
    else $error("Third pair dual grouping not under buck five.");
  a_third_reserved: assert property (@(posedge sys_clk) disable iff (srst)
    otp_load && !otp_done_ff && otp_cfg.third_pair_phase_config != bpv_pkg::GRP_DUAL
    |=> group_ff.ctrl_src[bpv_pkg::BUCK_SIX] == 3'(bpv_pkg::BUCK_SIX))
    else $error("Reserved third pair code not single.");
  a_phase_write: assert property (@(posedge sys_clk) disable iff (srst)
    phase_wr[bpv_pkg::BUCK_ONE] |=> phase_shift_select_ff[bpv_pkg::BUCK_ONE] == $past(phase_wdata))
    else $error("Phase field write lost.");

  // --------------------------------------------------------------
  // Sequencer checks
  // --------------------------------------------------------------
  // A ramp spans at most the full code range plus the compare cycle.
  // Anything longer means the goal moved away or the sequencer is stuck.
  logic [8:0] ramp_cnt_ff;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ramp_cnt_ff <= '0;
    end else if (state_ff == bpv_pkg::BPV_RAMP_START || state_ff == bpv_pkg::BPV_RAMP_SETPOINT) begin
      ramp_cnt_ff <= ramp_cnt_ff + 9'h001;
    end else begin
      ramp_cnt_ff <= '0;
    end
  end

  a_ramp_bounded: assert property (@(posedge sys_clk) disable iff (srst)
    ramp_cnt_ff <= bpv_pkg::RAMP_LIMIT)
    else $error("Buck six ramp did not finish.");
  a_ramp_moves: assert property (@(posedge sys_clk) disable iff (srst)
    state_ff == bpv_pkg::BPV_RAMP_START && buck_six_target_ff != track_start_ff
    && buck_six_enable && termination_mode_enable |=> buck_six_target_ff != $past(buck_six_target_ff))
    else $error("Start level ramp stalled.");
  a_reenable_ramp: assert property (@(posedge sys_clk) disable iff (srst)
    state_ff == bpv_pkg::BPV_RAMP_SETPOINT && buck_six_target_ff != six_setpoint
    && buck_six_enable && termination_mode_enable |=> !track_reference_ff)
    else $error("Tracking resumed before setpoint reached.");
  a_five_off_track: assert property (@(posedge sys_clk) disable iff (srst)
    state_ff == bpv_pkg::BPV_TRACK && buck_six_enable && termination_mode_enable && !buck_five_enable
    |=> track_reference_ff)
    else $error("Buck six stopped tracking with buck five off.");
  a_discharge_zero: assert property (@(posedge sys_clk) disable iff (srst)
    state_ff == bpv_pkg::BPV_DISCHARGE |=> state_ff == bpv_pkg::BPV_OFF
    && buck_six_target_ff == bpv_pkg::SETPOINT_ZERO)
    else $error("Buck six target not cleared on disable.");
  a_dvs_restore: assert property (@(posedge sys_clk) disable iff (srst)
    !termination_mode_enable |=> buck_six_dvs_enable_ff)
    else $error("Voltage scaling not restored outside termination mode.");

  c_track: cover property (@(posedge sys_clk) disable iff (srst) state_ff == bpv_pkg::BPV_TRACK);
  c_ramp: cover property (@(posedge sys_clk) disable iff (srst)
    state_ff == bpv_pkg::BPV_RAMP_START ##1 state_ff == bpv_pkg::BPV_TRACK);
  c_reenable: cover property (@(posedge sys_clk) disable iff (srst)
    state_ff == bpv_pkg::BPV_RAMP_SETPOINT ##1 state_ff == bpv_pkg::BPV_TRACK);
  c_five_off: cover property (@(posedge sys_clk) disable iff (srst)
    state_ff == bpv_pkg::BPV_TRACK && buck_five_pulldown_ff && buck_six_pulldown_ff);
  c_six_pulldown: cover property (@(posedge sys_clk) disable iff (srst)
    buck_six_pulldown_ff && !buck_five_pulldown_ff);

endmodule

// [dv/bpv_host.sv]
`timescale 1ns/10ps
// ----------------------------------------
// Host model
// ----------------------------------------
module bpv_host (
  input wire logic [7:0] five_run,
  input wire logic [7:0] five_stby,
  output logic [7:0] feedback_code,
  output logic [7:0] six_run,
  output logic [7:0] six_stby
);
  // Buck five is never set below 800 mV, so halving it stays in range.
  localparam logic [7:0] MIN_FIVE = 8'h40;
  always_comb begin
    feedback_code = (five_run < MIN_FIVE) ? MIN_FIVE : five_run;
    six_run = feedback_code >> 1;
    six_stby = ((five_stby < MIN_FIVE) ? MIN_FIVE : five_stby) >> 1;
  end
endmodule

// [dv/buck_phase_and_vtt_control_tb.sv]
`timescale 1ns/10ps
module buck_phase_and_vtt_control_tb;
  // ----------------------------------------
  // Stimulus and design
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic otp_load = 1'b0;
  bpv_pkg::bpv_otp_t otp_cfg = '0;
  logic term_en = 1'b0, stby = 1'b0, five_en = 1'b0, six_en = 1'b0, same_slot = 1'b0;
  logic [7:0] five_run = 8'h60, five_stby = 8'h50, fb, six_run, six_stby;
  logic [5:0] phase_wr = '0;
  logic [2:0] phase_wdata = '0;
  bpv_pkg::bpv_group_t grp;
  logic b4s, tref, dynamic_voltage_scaling, six_on, pd5, pd6;
  logic [5:0][2:0] phase;
  logic [7:0] tgt;
  int num_errors = 0;
  int comparisons = 0;
  always #10 sys_clk = ~sys_clk;
  bpv_host i_bpv_host (.five_run(five_run), .five_stby(five_stby), .feedback_code(fb),
    .six_run(six_run), .six_stby(six_stby));
  bpv_ctrl i_bpv_ctrl (.sys_clk(sys_clk), .srst(srst), .otp_load(otp_load), .otp_cfg(otp_cfg),
    .termination_mode_enable(term_en), .standby_mode(stby), .buck_five_enable(five_en),
    .buck_six_enable(six_en), .buck_six_same_slot(same_slot), .buck_five_feedback_code(fb),
    .buck_six_run_setpoint(six_run), .buck_six_standby_setpoint(six_stby), .phase_wr(phase_wr),
    .phase_wdata(phase_wdata), .group_ff(grp), .buck_four_single_ff(b4s), .phase_shift_select_ff(phase),
    .track_reference_ff(tref), .buck_six_dvs_enable_ff(dynamic_voltage_scaling), .buck_six_target_ff(tgt),
    .buck_six_on_ff(six_on), .buck_five_pulldown_ff(pd5), .buck_six_pulldown_ff(pd6));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic adv(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic restart(input logic [5:0] c, input logic pd);
    srst <= 1'b1;
    {term_en, five_en, six_en, stby} <= '0;
    adv(16);
    srst <= 1'b0;
    otp_cfg <= '{c[5:4], c[3:2], c[1:0], pd, 8'h10};
    otp_load <= 1'b1;
    adv(1);
    otp_load <= 1'b0;
    adv(1);
  endtask
  task automatic wait_ref;
    int n;
    n = 0;
    while (tref !== 1'b1 && n < 300) begin
      adv(1);
      n++;
    end
    chk(8'(tref), 8'h01, "tracking start");
  endtask
  task automatic complete_run;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_phase;
    srst <= 1'b1;
    adv(16);
    for (int i = 0; i < 6; i++) chk(8'(phase[i]), 8'h07, "phase reset");
    chk(8'(b4s), 8'h01, "four single reset");
    srst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      phase_wr <= 6'(1 << i);
      phase_wdata <= 3'(i);
      adv(1);
    end
    phase_wr <= '0;
    adv(1);
    for (int i = 0; i < 6; i++) chk(8'(phase[i]), 8'(i), "phase own field");
  endtask
  task automatic t_group;
    logic [5:0] cs [6] = '{6'h00, 6'h15, 6'h26, 6'h37, 6'h08, 6'h0D};
    int e [6];
    logic [1:0] f, s;
    foreach (cs[k]) begin
      restart(cs[k], 1'b0);
      f = cs[k][5:4];
      s = cs[k][3:2];
      e = '{0, (f == 2'h0) ? 1 : 0, (f >= 2'h2) ? 0 : ((s == 2'h1) ? 3 : 2), (f == 2'h2) ? 0 : 3, 4,
        (cs[k][1:0] == 2'h1) ? 4 : 5};
      for (int i = 0; i < 6; i++) chk(8'(grp.ctrl_src[i]), 8'(e[i]), "group source");
      chk(8'(b4s), 8'((f == 2'h3) || (f < 2'h2 && s != 2'h1)), "four single");
    end
    otp_cfg <= '0;
    otp_load <= 1'b1;
    adv(2);
    otp_load <= 1'b0;
    chk(8'(grp.ctrl_src[5]), 8'h04, "group static");
  endtask
  task automatic t_same_slot;
    restart(6'h00, 1'b0);
    five_run <= 8'h60;
    {term_en, five_en, six_en, same_slot} <= 4'hF;
    adv(2);
    wait_ref();
    adv(1);
    chk(tgt, 8'h30, "track half");
    chk(8'(dynamic_voltage_scaling), 8'h00, "scaling off");
    six_en <= 1'b0;
    adv(3);
    chk(8'(pd6), 8'h00, "six high impedance");
  endtask
  task automatic t_late;
    restart(6'h00, 1'b1);
    same_slot <= 1'b0;
    {term_en, five_en, six_en} <= 3'h7;
    adv(3);
    chk(8'(tref), 8'h00, "ramp first");
    wait_ref();
    chk(tgt, 8'h10, "start level");
    adv(2);
    chk(tgt, 8'h30, "then tracks");
    chk(8'(six_on), 8'h01, "six has run");
    six_en <= 1'b0;
    adv(3);
    chk(8'(pd6), 8'h01, "six pulled down");
    stby <= 1'b1;
    six_en <= 1'b1;
    adv(2);
    wait_ref();
    chk(tgt, 8'h28, "standby setpoint");
    adv(2);
    chk(tgt, 8'h30, "tracks again");
    stby <= 1'b0;
    five_en <= 1'b0;
    adv(3);
    chk({pd5, pd6, tref}, 8'h07, "both discharge");
    five_en <= 1'b1;
    five_run <= 8'h70;
    adv(3);
    chk({pd5, pd6}, 8'h00, "pulldowns off");
    chk(tgt, 8'h38, "half of five");
  endtask
  initial begin
    t_phase();
    t_group();
    t_same_slot();
    t_late();
    complete_run();
  end
  initial begin
    adv(5000);
    num_errors++;
    complete_run();
  end
endmodule
